// ===== hdl/dbs_pkg.sv
// shared constants, types and pin bundles for the burst sram command port
package dbs_pkg;

    // ========================================================
    // widths
    localparam int ADDR_W = 20;          // external address lines, burst bit excluded
    localparam int DATA_W = 36;          // widest data variant
    localparam int MEM_IDX_W = 10;       // index bits per array, 1024 stored locations (simulation model depth)
    localparam int NUM_ARRAYS = 2;       // two internal arrays, one per burst word

    // ========================================================
    // organisation straps
    localparam logic [1:0] ORG_X8 = 2'h0;
    localparam logic [1:0] ORG_X9 = 2'h1;
    localparam logic [1:0] ORG_X18 = 2'h2;
    localparam logic [1:0] ORG_X36 = 2'h3;

    // data lanes per organisation
    localparam logic [DATA_W-1:0] MASK_X8 = 36'h0000000FF;
    localparam logic [DATA_W-1:0] MASK_X9 = 36'h0000001FF;
    localparam logic [DATA_W-1:0] MASK_X18 = 36'h00003FFFF;
    localparam logic [DATA_W-1:0] MASK_X36 = 36'hFFFFFFFFF;

    // address lines used by the 36-bit variant (19 lines incl. burst bit)
    localparam logic [ADDR_W-1:0] AMASK_X36 = 20'h3FFFF;
    localparam logic [ADDR_W-1:0] AMASK_X18 = 20'h7FFFF;
    localparam logic [ADDR_W-1:0] AMASK_NARROW = 20'hFFFFF;

    // ========================================================
    // reset values
    localparam logic [DATA_W-1:0] RST_DQ = 36'h000000000;
    localparam logic [ADDR_W-1:0] RST_LOC = 20'h00000;

    // ========================================================
    // pin bundle order inside the synchroniser vector
    localparam int PIN_K = 0;            // positive input clock
    localparam int PIN_KB = 1;           // negative input clock
    localparam int PIN_C = 2;            // positive output clock
    localparam int PIN_CB = 3;           // negative output clock
    localparam int NUM_CLK_PINS = 4;

    typedef struct packed {
        logic [DATA_W-1:0] dq;           // data pins, input side
        logic single_clk;                // high: read data on input clock pair
        logic [1:0] org;                 // organisation strap
        logic [ADDR_W-1:0] addr;         // shared address lines
        logic burst_start_bit;           // burst counter start
        logic rw;                        // high read, low write
        logic load_strobe_n;             // active-low load
        logic cb_clk;
        logic c_clk;
        logic kb_clk;
        logic k_clk;
    } dbs_pins_t;

    localparam int PINS_W = $bits(dbs_pins_t);

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_WR_A,
        ST_WR_B,
        ST_RD_A,
        ST_RD_B
    } dbs_state_t;

    typedef struct packed {
        dbs_state_t state;
        logic [ADDR_W-1:0] loc;          // location shared by both arrays
        logic cnt;                       // burst counter, selects the array
        logic [1:0] org;                 // organisation latched with the command
        logic [DATA_W-1:0] dq_out;
        logic dq_oe;
    } dbs_regs_t;

endpackage

// ===== hdl/dbs_pin_sync.sv
// two-flop synchroniser for pin inputs with rising-edge detect on the low bits
`timescale 1ns/1ps
`default_nettype none

module dbs_pin_sync #(
    parameter int W = 8,
    parameter int NE = 1
) (
    input wire logic clk,                // system clock
    input wire logic rst_n,              // synchronous reset, active low
    input wire logic [W-1:0] pin_in,     // raw pins
    output logic [W-1:0] pin_sync,       // pins after two flops
    output logic [NE-1:0] pin_rise       // one-cycle pulse on rising pin
);

    // ========================================================
    // synchroniser stages
    logic [W-1:0] meta_reg;
    logic [W-1:0] sync_reg;
    logic [NE-1:0] last_reg;

    // first stage feeds only the second; edges look at stage two and its delay
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_reg <= '0;
            sync_reg <= '0;
            last_reg <= '0;
        end else begin
            meta_reg <= pin_in;
            sync_reg <= meta_reg;
            last_reg <= sync_reg[NE-1:0];
        end
    end

    assign pin_sync = sync_reg;
    assign pin_rise = sync_reg[NE-1:0] & ~last_reg;

endmodule

`default_nettype wire

// ===== hdl/dbs_cmd_port.sv
// address, command and clock front end of a two-word burst ddr sram
//
// Operation
// RULE1: two arrays; burst bit selects the word
// RULE2: narrow variants force internal address LSB zero
// RULE3: wide variants load burst bit, count linearly
// RULE4: one address bus, direction from select
// RULE5: addresses ignored unless load strobe low
// RULE6: select high reads, low writes
// RULE7: accesses start only on K rising edge
// RULE8: write words captured on K and K-bar
// RULE9: read data driven on output clock pair
// RULE10: single clock mode uses input clock pair
// RULE11: each load moves a burst of two
// RULE12: data pins released when no read
// RULE13: controller presents command with the strobe
`timescale 1ns/1ps
`default_nettype none

module dbs_cmd_port (
    input wire logic clk,                               // 20 MHz system clock
    input wire logic rst_n,                             // synchronous reset, active low
    input wire logic k_clk,                             // positive input clock pin
    input wire logic kb_clk,                            // negative input clock pin
    input wire logic c_clk,                             // positive output clock pin
    input wire logic cb_clk,                            // negative output clock pin
    input wire logic single_clk,                        // strap: no output clock pair
    input wire logic [1:0] org,                         // strap: organisation
    input wire logic load_strobe_n,                     // load strobe, active low
    input wire logic rw,                                // read high, write low
    input wire logic burst_start_bit,                   // burst counter start
    input wire logic [dbs_pkg::ADDR_W-1:0] addr,        // shared address lines
    input wire logic [dbs_pkg::DATA_W-1:0] dq_in,       // data pins, input side
    output logic [dbs_pkg::DATA_W-1:0] dq_out,          // data pins, output side
    output logic dq_oe                                  // data pins driven while high
);

    // ========================================================
    // pin synchronisation
    dbs_pkg::dbs_pins_t pins_raw;
    dbs_pkg::dbs_pins_t pins;
    logic [dbs_pkg::PINS_W-1:0] pins_vec;
    logic [dbs_pkg::NUM_CLK_PINS-1:0] rise;

    // every pin, clocks included, goes through the same two flops so the
    // sampled data stays aligned with the detected clock edge
    always_comb begin
        pins_raw.dq = dq_in;
        pins_raw.single_clk = single_clk;
        pins_raw.org = org;
        pins_raw.addr = addr;
        pins_raw.burst_start_bit = burst_start_bit;
        pins_raw.rw = rw;
        pins_raw.load_strobe_n = load_strobe_n;
        pins_raw.cb_clk = cb_clk;
        pins_raw.c_clk = c_clk;
        pins_raw.kb_clk = kb_clk;
        pins_raw.k_clk = k_clk;
    end

    dbs_pin_sync #(
        .W(dbs_pkg::PINS_W),
        .NE(dbs_pkg::NUM_CLK_PINS)
    ) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .pin_in(pins_raw),
        .pin_sync(pins_vec),
        .pin_rise(rise)
    );

    assign pins = pins_vec;

    // ========================================================
    // edge events
    logic k_rise;
    logic kb_rise;
    logic out_pos;
    logic out_neg;

    assign k_rise = rise[dbs_pkg::PIN_K];                                     // [RULE7]
    assign kb_rise = rise[dbs_pkg::PIN_KB];
    // output edges come from K pair in single clock mode, else from C pair
    assign out_pos = pins.single_clk ? rise[dbs_pkg::PIN_K] : rise[dbs_pkg::PIN_C];   // [RULE9] [RULE10]
    assign out_neg = pins.single_clk ? rise[dbs_pkg::PIN_KB] : rise[dbs_pkg::PIN_CB]; // [RULE9] [RULE10]

    // ========================================================
    // helpers

    // lanes that exist in the strapped organisation
    function automatic logic [dbs_pkg::DATA_W-1:0] lane_mask(input logic [1:0] o);
        case (o)
            dbs_pkg::ORG_X8: lane_mask = dbs_pkg::MASK_X8;
            dbs_pkg::ORG_X9: lane_mask = dbs_pkg::MASK_X9;
            dbs_pkg::ORG_X18: lane_mask = dbs_pkg::MASK_X18;
            default: lane_mask = dbs_pkg::MASK_X36;
        endcase
    endfunction

    // location from address lines; the burst bit is handled apart
    function automatic logic [dbs_pkg::ADDR_W-1:0] loc_of(input logic [1:0] o,
                                                          input logic [dbs_pkg::ADDR_W-1:0] a);
        case (o)
            dbs_pkg::ORG_X36: loc_of = a & dbs_pkg::AMASK_X36;               // [RULE3]
            dbs_pkg::ORG_X18: loc_of = a & dbs_pkg::AMASK_X18;               // [RULE3]
            default: loc_of = a & dbs_pkg::AMASK_NARROW;                     // [RULE2]
        endcase
    endfunction

    // narrow variants start the counter at zero, wide ones at the burst bit
    function automatic logic cnt_start(input logic [1:0] o, input logic b);
        cnt_start = (o == dbs_pkg::ORG_X18 || o == dbs_pkg::ORG_X36) ? b : 1'b0; // [RULE2] [RULE3]
    endfunction

    // ========================================================
    // storage: two arrays, one per burst word
    // the model keeps only the low index bits of each location
    logic [dbs_pkg::DATA_W-1:0] mem [dbs_pkg::NUM_ARRAYS][2**dbs_pkg::MEM_IDX_W];
    logic [dbs_pkg::MEM_IDX_W-1:0] idx;
    logic [dbs_pkg::DATA_W-1:0] rd_word;
    logic wr_en;
    logic wr_arr;

    // ========================================================
    // control state
    dbs_pkg::dbs_regs_t r;
    dbs_pkg::dbs_regs_t r_next;
    logic cmd_ok;

    // index taken from the latched location so a stray address change mid-burst is harmless
    assign idx = r.loc[dbs_pkg::MEM_IDX_W-1:0];
    logic accept;

    // a load counts only at K rise with the strobe low
    assign cmd_ok = k_rise && !pins.load_strobe_n;                            // [RULE5] [RULE7]

    // array read mux follows the burst counter
    assign rd_word = mem[r.cnt][idx] & lane_mask(r.org);                      // [RULE1]

    always_comb begin
        r_next = r;
        wr_en = 1'b0;
        wr_arr = r.cnt;
        accept = 1'b0;
        case (r.state)
            dbs_pkg::ST_IDLE: begin
                accept = 1'b1;
                // keep driving the last word until the next negative output edge
                if (out_neg) begin
                    r_next.dq_oe = 1'b0;                                      // [RULE12]
                end
            end
            dbs_pkg::ST_WR_A: begin
                // first word on the negative input clock after the load
                if (kb_rise) begin
                    wr_en = 1'b1;                                             // [RULE8]
                    r_next.state = dbs_pkg::ST_WR_B;
                end
            end
            dbs_pkg::ST_WR_B: begin
                // second word on the next K rise, which may also carry a load
                if (k_rise) begin
                    wr_en = 1'b1;                                             // [RULE8] [RULE11]
                    r_next.state = dbs_pkg::ST_IDLE;
                    accept = 1'b1;
                end
            end
            dbs_pkg::ST_RD_A: begin
                if (out_neg) begin
                    r_next.dq_out = rd_word;                                  // [RULE9] [RULE10]
                    r_next.dq_oe = 1'b1;
                    r_next.cnt = ~r.cnt;                                      // [RULE3]
                    r_next.state = dbs_pkg::ST_RD_B;
                end
            end
            dbs_pkg::ST_RD_B: begin
                if (out_pos) begin
                    r_next.dq_out = rd_word;                                  // [RULE9] [RULE11]
                    r_next.state = dbs_pkg::ST_IDLE;
                    // in single clock mode this edge is also K rise
                    accept = pins.single_clk;
                end
            end
            default: begin
                r_next.state = dbs_pkg::ST_IDLE;
            end
        endcase

        // new access: address, direction and burst bit from the same K rise
        if (accept && cmd_ok) begin
            r_next.loc = loc_of(pins.org, pins.addr);                         // [RULE4] [RULE13]
            r_next.cnt = cnt_start(pins.org, pins.burst_start_bit);           // [RULE2] [RULE3]
            r_next.org = pins.org;
            if (pins.rw) begin
                r_next.state = dbs_pkg::ST_RD_A;                              // [RULE6]
            end else begin
                r_next.state = dbs_pkg::ST_WR_A;                              // [RULE6]
                r_next.dq_oe = 1'b0;                                          // [RULE12]
            end
        end

        // after a write word the counter steps linearly to the other array
        if (wr_en) begin
            r_next.cnt = ~r.cnt;                                              // [RULE3]
            if (r.state == dbs_pkg::ST_WR_B && accept && cmd_ok) begin
                r_next.cnt = cnt_start(pins.org, pins.burst_start_bit);
            end
        end
    end

    // ========================================================
    // state register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            r.state <= dbs_pkg::ST_IDLE;
            r.loc <= dbs_pkg::RST_LOC;
            r.cnt <= 1'b0;
            r.org <= dbs_pkg::ORG_X36;
            r.dq_out <= dbs_pkg::RST_DQ;
            r.dq_oe <= 1'b0;
        end else begin
            r <= r_next;
        end
    end

    // array write port; lanes outside the organisation are stored as zero
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_arr][idx] <= pins.dq & lane_mask(r.org);                   // [RULE1] [RULE8]
        end
    end

    assign dq_out = r.dq_out;
    assign dq_oe = r.dq_oe;

endmodule

`default_nettype wire

// ===== sim/dbs_cmd_port_props.sv
// assertion checker for the burst sram command port pins
`timescale 1ns/1ps
`default_nettype none

module dbs_cmd_port_props (
    input wire logic clk, // system clock
    input wire logic rst_n, // reset, active low
    input wire logic k_clk, // K pin
    input wire logic kb_clk, // K-bar pin
    input wire logic c_clk, // C pin
    input wire logic cb_clk, // C-bar pin
    input wire logic single_clk, // single clock strap
    input wire logic [1:0] org, // organisation strap
    input wire logic load_strobe_n, // load, active low
    input wire logic rw, // read high
    input wire logic burst_start_bit, // burst start
    input wire logic [dbs_pkg::ADDR_W-1:0] addr, // address
    input wire logic [dbs_pkg::DATA_W-1:0] dq_in, // write data
    input wire logic [dbs_pkg::DATA_W-1:0] dq_out, // read data
    input wire logic dq_oe // data driven
);
    // ========================================================
    // helper ages
    logic neg_sel, pos_sel, last_rd;
    logic [5:0] neg_age, pos_age, cmd_age;
    logic [dbs_pkg::DATA_W-1:0] lane_mask;
    assign neg_sel = single_clk ? kb_clk : cb_clk;
    assign pos_sel = single_clk ? k_clk : c_clk;
    assign lane_mask = (org == dbs_pkg::ORG_X8) ? dbs_pkg::MASK_X8 :
        (org == dbs_pkg::ORG_X9) ? dbs_pkg::MASK_X9 :
        (org == dbs_pkg::ORG_X18) ? dbs_pkg::MASK_X18 : dbs_pkg::MASK_X36;
    // ages saturate so long idle stretches never wrap into a false window
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            neg_age <= 6'h3F;
            pos_age <= 6'h3F;
            cmd_age <= 6'h3F;
            last_rd <= 1'b0;
        end else begin
            neg_age <= $rose(neg_sel) ? 6'h00 : neg_age + {5'h00, neg_age != 6'h3F};
            pos_age <= $rose(pos_sel) ? 6'h00 : pos_age + {5'h00, pos_age != 6'h3F};
            cmd_age <= ($rose(k_clk) && !load_strobe_n) ? 6'h00 :
                cmd_age + {5'h00, cmd_age != 6'h3F};
            last_rd <= ($rose(k_clk) && !load_strobe_n) ? rw : last_rd;
        end
    end

    default clocking dclk @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_reset_quiet: assert property (
        $rose(rst_n) |-> !dq_oe && dq_out == dbs_pkg::RST_DQ) else $error("outputs busy at reset");
    a_oe_after_neg: assert property (
        $rose(dq_oe) |-> neg_age inside {[1:6]}) else $error("drive began off a negative edge");
    a_oe_fall_cause: assert property (
        $fell(dq_oe) |-> neg_age <= 6'd6 || cmd_age <= 6'd6) else $error("drive dropped uncaused");
    a_out_cause: assert property (
        $changed(dq_out) |-> neg_age <= 6'd6 || pos_age <= 6'd6) else $error("data moved off edge");
    a_read_answers: assert property (
        $rose(neg_sel) && last_rd && cmd_age < 6'd16 |-> ##[1:6] dq_oe) else $error("read no drive");
    a_write_no_oe: assert property (
        !last_rd && cmd_age == 6'd8 |-> !dq_oe) else $error("data driven during write");
    a_lanes_clear: assert property (
        $changed(dq_out) |-> (dq_out & ~lane_mask) == '0) else $error("unused lanes not zero");
    a_stray_quiet: assert property (
        $rose(k_clk) && load_strobe_n && !dq_oe && cmd_age > 6'd40
        |-> ##1 (!dq_oe) [*8] ##1 (!dq_oe) [*8]) else $error("access without load");
endmodule

`default_nettype wire

// ===== sim/dbs_ctrl_model.sv
// behavioural memory controller driving the sram pins
`timescale 1ns/1ps
`default_nettype none

module dbs_ctrl_model (
    input wire logic clk, // system clock
    input wire logic [dbs_pkg::DATA_W-1:0] dq_out, // read data
    input wire logic dq_oe, // data driven
    output logic k_clk, // K
    output logic kb_clk, // K-bar
    output logic c_clk, // C
    output logic cb_clk, // C-bar
    output logic load_strobe_n, // load, active low
    output logic rw, // read high
    output logic burst_start_bit, // burst start
    output logic [dbs_pkg::ADDR_W-1:0] addr, // address
    output logic [dbs_pkg::DATA_W-1:0] dq_in // write data
);
    // ========================================================
    // pin clocks stand still low between bursts
    initial begin
        {k_clk, kb_clk, c_clk, cb_clk, rw, burst_start_bit} = 6'h00;
        load_strobe_n = 1'b1;
        addr = '0;
        dq_in = '0;
    end

    // four clk per phase keeps each pin phase above the sync depth
    task automatic pulse(input int p);
        case (p)
            dbs_pkg::PIN_K: k_clk <= 1'b1;
            dbs_pkg::PIN_KB: kb_clk <= 1'b1;
            dbs_pkg::PIN_C: c_clk <= 1'b1;
            default: cb_clk <= 1'b1;
        endcase
        repeat (4) @(posedge clk);
        {k_clk, kb_clk, c_clk, cb_clk} <= 4'h0;
        repeat (4) @(posedge clk);
    endtask

    // command sits with the strobe at one K rise, then the address lines are inverted
    task automatic load_cmd(input logic r, input logic [19:0] a, input logic bb);
        load_strobe_n <= 1'b0;
        rw <= r;
        addr <= a;
        burst_start_bit <= bb;
        pulse(dbs_pkg::PIN_K);
        load_strobe_n <= 1'b1;
        addr <= ~a;
    endtask

    task automatic write_burst(input logic [19:0] a, input logic bb,
                               input logic [35:0] w0, input logic [35:0] w1);
        load_cmd(1'b0, a, bb);
        dq_in <= w0;
        pulse(dbs_pkg::PIN_KB);
        dq_in <= w1;
        pulse(dbs_pkg::PIN_K);
        dq_in <= ~w1; // released lines no longer show the last word
    endtask

    task automatic read_burst(input logic [19:0] a, input logic bb, input logic single,
                              output logic [35:0] r0, output logic [35:0] r1,
                              output logic oe0, output logic oe_end);
        int neg;
        neg = single ? dbs_pkg::PIN_KB : dbs_pkg::PIN_CB;
        load_cmd(1'b1, a, bb);
        pulse(neg);
        r0 = dq_out;
        oe0 = dq_oe;
        pulse(single ? dbs_pkg::PIN_K : dbs_pkg::PIN_C);
        r1 = dq_out;
        pulse(neg);
        oe_end = dq_oe;
    endtask

    // an edge with the strobe in a given state, then a C-bar edge
    task automatic stray(input logic ld, input int p, output logic oe);
        load_strobe_n <= ld;
        rw <= 1'b1;
        pulse(p);
        load_strobe_n <= 1'b1;
        pulse(dbs_pkg::PIN_CB);
        oe = dq_oe;
    endtask
endmodule

`default_nettype wire

// ===== sim/tb.sv
// self-checking testbench for the burst sram command port
`timescale 1ns/1ps
`default_nettype none

module tb;
    logic clk, rst_n, single_clk, load_strobe_n, rw, burst_start_bit, dq_oe;
    logic k_clk, kb_clk, c_clk, cb_clk;
    logic [1:0] org;
    logic [19:0] addr;
    logic [35:0] dq_in, dq_out;
    int num_errors, num_checks;

    dbs_cmd_port DUT (.clk(clk), .rst_n(rst_n), .k_clk(k_clk), .kb_clk(kb_clk), .c_clk(c_clk),
        .cb_clk(cb_clk), .single_clk(single_clk), .org(org), .load_strobe_n(load_strobe_n),
        .rw(rw), .burst_start_bit(burst_start_bit), .addr(addr), .dq_in(dq_in),
        .dq_out(dq_out), .dq_oe(dq_oe));
    dbs_ctrl_model u_ctrl (.clk(clk), .dq_out(dq_out), .dq_oe(dq_oe), .k_clk(k_clk),
        .kb_clk(kb_clk), .c_clk(c_clk), .cb_clk(cb_clk), .load_strobe_n(load_strobe_n),
        .rw(rw), .burst_start_bit(burst_start_bit), .addr(addr), .dq_in(dq_in));

    // ========================================================
    // compares and verdict
    always #25 clk = ~clk;

    task automatic check_word(input logic [35:0] got, input logic [35:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_bit(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic print_verdict();
        if (num_errors == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // every organisation: write with burst bit set, read back from zero
    task automatic t_org_bursts();
        logic [35:0] w0, w1, r0, r1, m;
        logic oe0, oe_end;
        for (int o = 0; o < 4; o++) begin
            org <= o[1:0];
            repeat (8) @(posedge clk);
            m = (o == 0) ? dbs_pkg::MASK_X8 : (o == 1) ? dbs_pkg::MASK_X9 :
                (o == 2) ? dbs_pkg::MASK_X18 : dbs_pkg::MASK_X36;
            w0 = 36'hA5C3E1F79 ^ {32'h00000000, o[3:0]};
            w1 = 36'h5E3C1A786 ^ {32'h00000000, o[3:0]};
            u_ctrl.write_burst({18'h00011, o[1:0]}, 1'b1, w0, w1);
            u_ctrl.read_burst({18'h00011, o[1:0]}, 1'b0, 1'b0, r0, r1, oe0, oe_end);
            check_word(r0, (o < 2) ? (w0 & m) : (w1 & m));
            check_word(r1, (o < 2) ? (w1 & m) : (w0 & m));
            check_bit(oe0, 1'b1);
            check_bit(oe_end, 1'b0);
        end
    endtask

    // single clock mode returns data on the input clock pair
    task automatic t_single();
        logic [35:0] r0, r1;
        logic oe0, oe_end;
        single_clk <= 1'b1;
        org <= dbs_pkg::ORG_X36;
        repeat (8) @(posedge clk);
        u_ctrl.write_burst(20'h00123, 1'b0, 36'h123456789, 36'hFEDCBA987);
        u_ctrl.read_burst(20'h00123, 1'b1, 1'b1, r0, r1, oe0, oe_end);
        check_word(r0, 36'hFEDCBA987);
        check_word(r1, 36'h123456789);
        check_bit(oe0, 1'b1);
        check_bit(oe_end, 1'b0);
        single_clk <= 1'b0;
        repeat (8) @(posedge clk);
    endtask

    // no access without the strobe, and none from a K-bar edge
    task automatic t_stray();
        logic oe;
        u_ctrl.stray(1'b1, dbs_pkg::PIN_K, oe);
        check_bit(oe, 1'b0);
        u_ctrl.stray(1'b0, dbs_pkg::PIN_KB, oe);
        check_bit(oe, 1'b0);
    endtask

    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        single_clk = 1'b0;
        org = dbs_pkg::ORG_X36;
        num_errors = 0;
        num_checks = 0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        t_org_bursts();
        t_single();
        t_stray();
        print_verdict();
    end

    // watchdog: a hang counts as a mismatch
    initial begin
        repeat (100000) @(posedge clk);
        num_errors++;
        print_verdict();
    end
endmodule

bind dbs_cmd_port dbs_cmd_port_props u_props (.clk, .rst_n, .k_clk, .kb_clk, .c_clk, .cb_clk,
    .single_clk, .org, .load_strobe_n, .rw, .burst_start_bit, .addr, .dq_in, .dq_out, .dq_oe);

`default_nettype wire
